// ===== pkg/spd_regs.svh
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH
`define SPD_OFF_CTRL1   8'h00
`define SPD_OFF_BUF     8'h04
`define SPD_OFF_STAT    8'h08
`define SPD_OFF_DCTRL1  8'h0c
`define SPD_OFF_DCTRL2  8'h10
`define SPD_OFF_TXPTR   8'h14
`define SPD_OFF_RXPTR   8'h18
`define SPD_OFF_COUNT   8'h1c
`define SPD_OFF_ISTAT   8'h20
`define SPD_OFF_ICLR    8'h24
`define SPD_OFF_IEN     8'h28
`define SPD_C1_WRITE_COLLISION_FLAG     7
`define SPD_C1_OVF      6
`define SPD_C1_EN       5
`define SPD_C1_CPOL     4
`define SPD_D1_EN       0
`define SPD_D1_TX       1
`define SPD_D1_RX       2
`define SPD_D2_SDO_OD   0
`define SPD_D2_SCK_OD   1
`define SPD_IRQ_XFER    0
`define SPD_IRQ_DMA     1
`define SPD_IRQ_WRITE_COLLISION_FLAG    2
`define SPD_IRQ_OVF     3
`define SPD_RST_BYTE    8'h00
`define SPD_RST_PTR     12'h000
`define SPD_RST_COUNT   10'h000
`define SPD_RST_IRQ     4'h0
`define SPD_IDLE_TX     8'hff
`define SPD_HALF_DIV64  6'd32
`define SPD_HALF_DIV16  6'd8
`define SPD_HALF_DIV8   6'd4
`endif

// ===== pkg/spd_pkg.sv
package spd_pkg;
	typedef enum logic [3:0]
	{
		SPD_SLV_NOSS = 4'h5,
		SPD_SLV_SS   = 4'h4,
		SPD_MST_TMR  = 4'h3,
		SPD_MST_D64  = 4'h2,
		SPD_MST_D16  = 4'h1,
		SPD_MST_D8   = 4'ha
	} spd_mode_t;
	typedef enum logic [1:0]
	{
		SPD_D_IDLE  = 2'b00,
		SPD_D_FETCH = 2'b01,
		SPD_D_SHIFT = 2'b10,
		SPD_D_STORE = 2'b11
	} spd_dstate_t;
endpackage : spd_pkg

// ===== pkg/spd_shift_if.sv
`timescale 1ns/1ps
interface spd_shift_if;
	logic       en;
	logic       master;
	logic       use_ss;
	logic       cpol;
	logic       sleep;
	logic [3:0] mode;
	logic       tick_tmr;
	logic       start;
	logic [7:0] tx_byte;
	logic       sck_in;
	logic       sdi_in;
	logic       ss_n_in;
	logic       done;
	logic [7:0] rx_byte;
	logic       busy;
	logic       sck_out;
	logic       sdo_out;
	logic       sdo_drive;
	modport shifter (input en, master, use_ss, cpol, sleep, mode, tick_tmr, start, tx_byte,
		sck_in, sdi_in, ss_n_in, output done, rx_byte, busy, sck_out, sdo_out, sdo_drive);
	modport ctrl (output en, master, use_ss, cpol, sleep, mode, tick_tmr, start, tx_byte,
		sck_in, sdi_in, ss_n_in, input done, rx_byte, busy, sck_out, sdo_out, sdo_drive);
endinterface : spd_shift_if

// ===== rtl/spd_sync.sv
`timescale 1ns/1ps
module spd_sync #(parameter int W = 1)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : spd_sync

// ===== rtl/spd_shift.sv
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_shift import spd_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	spd_shift_if.shifter sif
);
	logic [5:0] div;
	logic [5:0] half;
	logic       mtick;
	logic       ph;
	logic       sck_d;
	logic       samp;
	logic [7:0] sr;
	logic [2:0] bits;
	logic       ss_act;
	logic       lead;
	logic       trail;

	always_comb
	begin
		case (sif.mode)
			SPD_MST_D64: half = `SPD_HALF_DIV64;
			SPD_MST_D16: half = `SPD_HALF_DIV16;
			default:     half = `SPD_HALF_DIV8;
		endcase
	end

	// Master clock is gated off in sleep (mtick low, div held); slave keeps shifting
	assign mtick = sif.master && sif.busy && !sif.sleep &&
		((sif.mode == SPD_MST_TMR) ? sif.tick_tmr : (div == half - 6'd1)); // RULE_01 RULE_11
	assign ss_act = !sif.use_ss || !sif.ss_n_in; // RULE_01
	assign lead  = sif.master ? (mtick && !ph) :
		(ss_act && (sck_d == sif.cpol) && (sif.sck_in != sif.cpol));
	assign trail = sif.master ? (mtick && ph) :
		(ss_act && (sck_d != sif.cpol) && (sif.sck_in == sif.cpol));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div <= 6'd0;
		else if (!(sif.master && sif.busy) || mtick)
			div <= 6'd0;
		else if (!sif.sleep)
			div <= div + 6'd1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sck_d <= 1'b0;
		else
			sck_d <= sif.sck_in;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr          <= `SPD_RST_BYTE;
			bits        <= 3'd0;
			ph          <= 1'b0;
			samp        <= 1'b0;
			sif.busy    <= 1'b0;
			sif.done    <= 1'b0;
			sif.rx_byte <= `SPD_RST_BYTE;
		end
		else if (!sif.en)
		begin
			bits     <= 3'd0;
			ph       <= 1'b0;
			sif.busy <= 1'b0;
			sif.done <= 1'b0;
		end
		else
		begin
			sif.done <= 1'b0;
			if (sif.start)
			begin
				sr       <= sif.tx_byte; // RULE_15
				bits     <= 3'd0;
				ph       <= 1'b0;
				sif.busy <= sif.master;
			end
			else if (!sif.master && !ss_act)
			begin
				bits     <= 3'd0;
				sif.busy <= 1'b0;
			end
			else if (lead)
			begin
				samp     <= sif.sdi_in;
				ph       <= 1'b1;
				sif.busy <= 1'b1;
			end
			else if (trail)
			begin
				sr   <= {sr[6:0], samp};
				ph   <= 1'b0;
				bits <= bits + 3'd1;
				if (bits == 3'd7)
				begin
					sif.done    <= 1'b1; // RULE_14
					sif.busy    <= 1'b0;
					sif.rx_byte <= {sr[6:0], samp};
				end
			end
		end
	end

	assign sif.sck_out   = sif.master ? (ph ^ sif.cpol) : sif.cpol;
	assign sif.sdo_out   = sr[7];
	assign sif.sdo_drive = sif.en && (sif.master || ss_act);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_master_go;
		sif.start && sif.master && sif.en;
	endsequence
	property p_master_byte;
		s_master_go |=> sif.busy;
	endproperty
	a_master_byte: assert property (p_master_byte) else $error("master did not start"); // RULE_06
	property p_done_clears_busy;
		sif.done |-> !sif.busy && bits == 3'd0;
	endproperty
	a_done_clears_busy: assert property (p_done_clears_busy) else $error("done with busy"); // RULE_14
endmodule : spd_shift

// ===== rtl/spd_top.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spd_regs.svh"
// Contract
// RULE_01 - Mode field picks slave and master clocks
// RULE_02 - Unlisted mode codes give no SPI activity
// RULE_03 - DMA moves bytes to and from SRAM
// RULE_04 - Without DMA, software uses buffer register
// RULE_05 - DMA holds pointers, count, control, interrupts
// RULE_06 - DMA in all modes, half/full duplex
// RULE_07 - Data and clock outputs optionally open-drain
// RULE_08 - Loopback master gives memory copy
// RULE_09 - DMA keeps running during idle
// RULE_10 - Software polls DMA enable before sleep
// RULE_11 - Slave byte in sleep sets flag
// RULE_12 - No DMA in sleep, no data lost
// RULE_13 - Deep sleep stops all; reinit after
// RULE_14 - Full byte goes to buffer, sets flag
// RULE_15 - Buffer write loads shift register too
// RULE_16 - DMA steps pointers, counts, self-clears enable
// RULE_17 - Port enable claims pins, else released
module spd_top import spd_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        SCK_I,
	output logic             SCK_O,
	output logic             SCK_OE,
	input  wire logic        SDI_I,
	output logic             SDO_O,
	output logic             SDO_OE,
	input  wire logic        SS_N_I,
	input  wire logic        TIMER_TICK,
	input  wire logic        SLEEP,
	input  wire logic        DEEP_SLEEP,
	output logic             MEM_REQ,
	output logic             MEM_WE,
	output logic [11:0]      MEM_ADDR,
	output logic [7:0]       MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic        MEM_ACK,
	output logic             IRQ
);
	spd_shift_if sif ();
	logic [2:0]  pins_q;
	logic        aw_full, w_full, next_aw_full, next_w_full, do_write, ar_take;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [31:0] rd_data;
	logic        rd_ok, wr_ok;
	logic        port_enable, clock_idle_polarity, write_collision_flag, receive_overflow_flag;
	logic [3:0]  port_mode_field;
	logic [7:0]  port_buffer;
	logic        buf_full;
	logic        dma_enable_bit, dma_tx, dma_rx, sdo_od, sck_od;
	logic [11:0] tx_ptr, rx_ptr;
	logic [9:0]  byte_count;
	logic [3:0]  irq_status, irq_enable, irq_ev;
	logic        mode_valid, mode_master;
	logic        buf_wr, buf_wr_ok, collide, overflow, dma_start, dma_done;
	logic [7:0]  dma_byte;
	spd_dstate_t dstate;

	spd_sync #(.W(3)) u_sync (.clk(SYS_CLK), .rst_n(RST_N), .d({SCK_I, SDI_I, SS_N_I}),
		.q(pins_q));
	spd_shift u_shift (.clk(SYS_CLK), .rst_n(RST_N), .sif(sif));

	always_comb
	begin
		case (port_mode_field)
			SPD_SLV_NOSS, SPD_SLV_SS: {mode_valid, mode_master} = 2'b10;
			SPD_MST_TMR, SPD_MST_D64, SPD_MST_D16, SPD_MST_D8: {mode_valid, mode_master} = 2'b11;
			default: {mode_valid, mode_master} = 2'b00; // RULE_02
		endcase
	end

	// Deep sleep stops the port entirely; the enables only come back through software
	assign sif.en       = port_enable && mode_valid && !DEEP_SLEEP; // RULE_02 RULE_13
	assign sif.master   = mode_master;
	assign sif.use_ss   = (port_mode_field == SPD_SLV_SS); // RULE_01
	assign sif.cpol     = clock_idle_polarity;
	assign sif.sleep    = SLEEP;
	assign sif.mode     = port_mode_field;
	assign sif.tick_tmr = TIMER_TICK;
	assign {sif.sck_in, sif.sdi_in, sif.ss_n_in} = pins_q;
	assign sif.start    = buf_wr_ok || dma_start; // RULE_04 RULE_15
	assign sif.tx_byte  = dma_start ? dma_byte : wdata_q[7:0];

	assign next_aw_full = do_write ? 1'b0 : (aw_full || (S_AXI_AWVALID && S_AXI_AWREADY));
	assign next_w_full  = do_write ? 1'b0 : (w_full || (S_AXI_WVALID && S_AXI_WREADY));
	assign do_write     = aw_full && w_full && !S_AXI_BVALID;
	assign ar_take      = S_AXI_ARVALID && S_AXI_ARREADY;
	assign wr_ok        = (awaddr_q <= `SPD_OFF_IEN) && (awaddr_q[1:0] == 2'b00);
	assign buf_wr       = do_write && awaddr_q == `SPD_OFF_BUF && wstrb_q[0];
	// A write during a byte in flight is dropped, as the shift register is single
	assign collide      = buf_wr && sif.busy;
	assign buf_wr_ok    = buf_wr && !sif.busy && !dma_start;
	assign overflow     = sif.done && buf_full && !mode_master && !dma_enable_bit;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			{aw_full, w_full, S_AXI_BVALID} <= 3'b000;
			{S_AXI_AWREADY, S_AXI_WREADY} <= 2'b00;
			awaddr_q    <= 8'h00;
			wdata_q     <= 32'h0000_0000;
			wstrb_q     <= 4'h0;
			S_AXI_BRESP <= 2'b00;
		end
		else
		begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			S_AXI_AWREADY <= !next_aw_full;
			S_AXI_WREADY  <= !next_w_full;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
				awaddr_q <= S_AXI_AWADDR;
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_ok ? 2'b00 : 2'b10;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	always_comb
	begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		case (S_AXI_ARADDR)
			`SPD_OFF_CTRL1:  rd_data[7:0] = {write_collision_flag, receive_overflow_flag,
				port_enable, clock_idle_polarity, port_mode_field};
			`SPD_OFF_BUF:    rd_data[7:0] = port_buffer;
			`SPD_OFF_STAT:   rd_data[1:0] = {sif.busy, buf_full};
			`SPD_OFF_DCTRL1: rd_data[2:0] = {dma_rx, dma_tx, dma_enable_bit};
			`SPD_OFF_DCTRL2: rd_data[1:0] = {sck_od, sdo_od};
			`SPD_OFF_TXPTR:  rd_data[11:0] = tx_ptr;
			`SPD_OFF_RXPTR:  rd_data[11:0] = rx_ptr;
			`SPD_OFF_COUNT:  rd_data[9:0] = byte_count;
			`SPD_OFF_ISTAT:  rd_data[3:0] = irq_status;
			`SPD_OFF_ICLR:   rd_data = 32'h0000_0000;
			`SPD_OFF_IEN:    rd_data[3:0] = irq_enable;
			default:         rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= 2'b00;
		end
		else
		begin
			S_AXI_ARREADY <= !(S_AXI_RVALID || ar_take) || (S_AXI_RVALID && S_AXI_RREADY);
			if (ar_take)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_data;
				S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			{port_enable, clock_idle_polarity, write_collision_flag, receive_overflow_flag} <= 4'h0;
			port_mode_field <= 4'h0;
			{sdo_od, sck_od} <= 2'b00;
			irq_enable <= `SPD_RST_IRQ;
		end
		else if (DEEP_SLEEP)
		begin
			{port_enable, clock_idle_polarity, write_collision_flag, receive_overflow_flag} <= 4'h0;
			port_mode_field <= 4'h0; // RULE_13
			{sdo_od, sck_od} <= 2'b00;
			irq_enable <= `SPD_RST_IRQ;
		end
		else
		begin
			if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_CTRL1)
			begin
				port_enable         <= wdata_q[`SPD_C1_EN];
				clock_idle_polarity <= wdata_q[`SPD_C1_CPOL];
				port_mode_field     <= wdata_q[3:0];
			end
			// Flags clear by writing zero or in deep sleep, and a new event wins over the written clear
			if (collide)
				write_collision_flag <= 1'b1;
			else if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_CTRL1)
				write_collision_flag <= write_collision_flag & wdata_q[`SPD_C1_WRITE_COLLISION_FLAG];
			if (overflow)
				receive_overflow_flag <= 1'b1;
			else if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_CTRL1)
				receive_overflow_flag <= receive_overflow_flag & wdata_q[`SPD_C1_OVF];
			if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_DCTRL2)
				{sck_od, sdo_od} <= wdata_q[1:0]; // RULE_07
			if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_IEN)
				irq_enable <= wdata_q[3:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			port_buffer <= `SPD_RST_BYTE;
			buf_full    <= 1'b0;
		end
		else
		begin
			if (sif.done && !overflow)
				port_buffer <= sif.rx_byte; // RULE_14
			else if (buf_wr_ok)
				port_buffer <= wdata_q[7:0]; // RULE_15
			if (sif.done && !dma_enable_bit)
				buf_full <= 1'b1; // RULE_11 RULE_12
			else if (ar_take && S_AXI_ARADDR == `SPD_OFF_BUF)
				buf_full <= 1'b0;
		end
	end

	// The engine never gates on an idle state, only on sleep, deep sleep and a disabled port (sif.en low)
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			dstate <= SPD_D_IDLE;
			{dma_enable_bit, dma_tx, dma_rx, dma_start, dma_done} <= 5'b00000;
			{MEM_REQ, MEM_WE} <= 2'b00;
			{MEM_ADDR, tx_ptr, rx_ptr} <= {`SPD_RST_PTR, `SPD_RST_PTR, `SPD_RST_PTR};
			{MEM_WDATA, dma_byte} <= {`SPD_RST_BYTE, `SPD_RST_BYTE};
			byte_count <= `SPD_RST_COUNT;
		end
		else if (DEEP_SLEEP || !sif.en)
		begin
			dstate <= SPD_D_IDLE; // RULE_13
			{dma_start, dma_done, MEM_REQ, MEM_WE} <= 4'h0;
			if (DEEP_SLEEP)
				{dma_enable_bit, dma_tx, dma_rx} <= 3'b000;
			else if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_DCTRL1)
				{dma_rx, dma_tx, dma_enable_bit} <= wdata_q[2:0];
		end
		else
		begin
			dma_start <= 1'b0;
			dma_done  <= 1'b0;
			if (dstate == SPD_D_IDLE && do_write && wstrb_q[0])
			begin
				if (awaddr_q == `SPD_OFF_DCTRL1)
					{dma_rx, dma_tx, dma_enable_bit} <= wdata_q[2:0];
				if (awaddr_q == `SPD_OFF_TXPTR)
					tx_ptr <= {wstrb_q[1] ? wdata_q[11:8] : tx_ptr[11:8], wdata_q[7:0]};
				if (awaddr_q == `SPD_OFF_RXPTR)
					rx_ptr <= {wstrb_q[1] ? wdata_q[11:8] : rx_ptr[11:8], wdata_q[7:0]};
				if (awaddr_q == `SPD_OFF_COUNT)
					byte_count <= {wstrb_q[1] ? wdata_q[9:8] : byte_count[9:8], wdata_q[7:0]};
			end
			case (dstate)
				SPD_D_IDLE:
					if (dma_enable_bit && !SLEEP && !dma_start) // RULE_09 RULE_10
					begin
						if (byte_count == 10'd0)
						begin
							dma_enable_bit <= 1'b0;
							dma_done       <= 1'b1;
						end
						else if (dma_tx)
						begin
							{MEM_REQ, MEM_WE} <= 2'b10; // RULE_03
							MEM_ADDR <= tx_ptr;
							dstate   <= SPD_D_FETCH;
						end
						else
						begin
							dma_byte  <= `SPD_IDLE_TX; // RULE_06
							dma_start <= 1'b1;
							dstate    <= SPD_D_SHIFT;
						end
					end
				SPD_D_FETCH:
					if (MEM_ACK)
					begin
						MEM_REQ   <= 1'b0;
						dma_byte  <= MEM_RDATA; // RULE_03
						dma_start <= 1'b1;
						dstate    <= SPD_D_SHIFT;
					end
				SPD_D_SHIFT:
					if (sif.done)
					begin
						if (dma_rx)
						begin
							{MEM_REQ, MEM_WE} <= 2'b11; // RULE_03 RULE_08
							MEM_ADDR  <= rx_ptr;
							MEM_WDATA <= sif.rx_byte;
							dstate    <= SPD_D_STORE;
						end
						else
							dstate <= SPD_D_IDLE;
					end
				SPD_D_STORE:
					if (MEM_ACK)
					begin
						{MEM_REQ, MEM_WE} <= 2'b00;
						dstate <= SPD_D_IDLE;
					end
				default: dstate <= SPD_D_IDLE;
			endcase
			if ((dstate == SPD_D_SHIFT && sif.done && !dma_rx) ||
				(dstate == SPD_D_STORE && MEM_ACK))
			begin
				tx_ptr     <= tx_ptr + {11'd0, dma_tx}; // RULE_16
				rx_ptr     <= rx_ptr + {11'd0, dma_rx};
				byte_count <= byte_count - 10'd1;
				if (byte_count == 10'd1)
				begin
					dma_enable_bit <= 1'b0; // RULE_16
					dma_done       <= 1'b1;
				end
			end
		end
	end

	assign irq_ev = {overflow, collide, dma_done, sif.done}; // RULE_05

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			irq_status <= `SPD_RST_IRQ;
			IRQ        <= 1'b0;
		end
		else
		begin
			if (do_write && wstrb_q[0] && awaddr_q == `SPD_OFF_ICLR)
				irq_status <= (irq_status & ~wdata_q[3:0]) | irq_ev;
			else
				irq_status <= irq_status | irq_ev;
			IRQ <= |(irq_status & irq_enable);
		end
	end

	// Pins are registered so the pads never see decode glitches
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			{SCK_O, SCK_OE, SDO_O, SDO_OE} <= 4'h0;
		else
		begin
			SCK_O  <= !sck_od && sif.sck_out; // RULE_07
			SCK_OE <= sif.en && mode_master && (!sck_od || !sif.sck_out); // RULE_17
			SDO_O  <= !sdo_od && sif.sdo_out;
			SDO_OE <= sif.sdo_drive && (!sdo_od || !sif.sdo_out); // RULE_07 RULE_17
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	property p_bad_mode;
		!mode_valid |=> !SCK_OE && !SDO_OE && !sif.busy;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("spi active in bad mode"); // RULE_02
	property p_pins_off;
		!port_enable |=> !SCK_OE && !SDO_OE;
	endproperty
	a_pins_off: assert property (p_pins_off) else $error("pins held while disabled"); // RULE_17
	property p_od;
		SDO_OE && $past(sdo_od) |-> !SDO_O;
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high"); // RULE_07
	property p_rx_buf;
		sif.done && !overflow |=> port_buffer == $past(sif.rx_byte) && irq_status[0];
	endproperty
	a_rx_buf: assert property (p_rx_buf) else $error("byte not moved to buffer"); // RULE_14
	property p_wr_buf;
		buf_wr_ok |=> port_buffer == $past(wdata_q[7:0]);
	endproperty
	a_wr_buf: assert property (p_wr_buf) else $error("buffer write lost"); // RULE_15
	property p_count_end;
		dstate == SPD_D_STORE && MEM_ACK && byte_count == 10'd1 && !DEEP_SLEEP && sif.en
			|=> !dma_enable_bit && byte_count == 10'd0 && dma_done;
	endproperty
	a_count_end: assert property (p_count_end) else $error("dma did not stop"); // RULE_16
	property p_deep;
		DEEP_SLEEP |=> !port_enable && !dma_enable_bit && !MEM_REQ;
	endproperty
	a_deep: assert property (p_deep) else $error("active in deep sleep"); // RULE_13
	sequence s_fetch;
		dstate == SPD_D_FETCH && MEM_ACK && sif.en && !DEEP_SLEEP;
	endsequence
	property p_fetch_go;
		s_fetch |=> dma_start ##1 sif.busy || !mode_master;
	endproperty
	a_fetch_go: assert property (p_fetch_go) else $error("fetched byte not sent"); // RULE_03
	property p_irq;
		|(irq_status & irq_enable) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE_05
	property p_sleep_hold;
		SLEEP && dstate == SPD_D_IDLE |=> dstate == SPD_D_IDLE;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("dma ran in sleep"); // RULE_12
endmodule : spd_top

// ===== test/spd_spi_peer.sv
`timescale 1ns/1ps
module spd_spi_peer
(
	input  wire logic       sck,
	input  wire logic       cpol,
	input  wire logic       sdo,
	input  wire logic [7:0] tx,
	output logic            sdi,
	output logic      [7:0] rx
);
	logic [7:0] sh;
	int         n = 0;
	initial
	begin
		#1;
		sh = tx;
	end
	// MSB first, sample on leading edge, shift on trailing edge
	// Any change to the active level counts a bit, even from an unknown level before reset settles
	always @(sck)
	begin
		if (sck === !cpol)
		begin
			rx = {rx[6:0], sdo};
			n = n + 1;
		end
		else if (sck === cpol && n == 8)
		begin
			sh = tx;
			n = 0;
		end
		else if (sck === cpol && n > 0)
			sh = {sh[6:0], 1'b0};
	end
	assign sdi = sh[7];
endmodule : spd_spi_peer

// ===== test/spd_top_tb.sv
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_top_tb import spd_pkg::*;
;
	logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, tick = 0, mem_ack = 0, sleep = 0;
	logic [7:0]  awaddr = 0, araddr = 0, mem_rdata = 0, prx, mem_wdata;
	logic [31:0] wdata = 0, rdata, d;
	logic [1:0]  tcnt = 0, bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdo_o, sdo_oe;
	logic        sdi, mem_req, mem_we, irq;
	logic [11:0] mem_addr;
	logic [7:0]  mem [0:4095];
	int          num_errors = 0, compares = 0, cyc = 0;
	// SCK line has a pull-down, so idle low with polarity 0 gives no false edges
	wire         sck_w = sck_oe ? sck_o : 1'b0;
	spd_top dut_u (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
		.SDI_I(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SS_N_I(1'b1), .TIMER_TICK(tick),
		.SLEEP(sleep), .DEEP_SLEEP(1'b0), .MEM_REQ(mem_req), .MEM_WE(mem_we),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
		.MEM_ACK(mem_ack), .IRQ(irq));
	spd_spi_peer peer_u (.sck(sck_w), .cpol(1'b0), .sdo(sdo_o), .tx(8'h3c), .sdi(sdi),
		.rx(prx));
	initial
		forever #10 clk = ~clk;
	always @(posedge clk)
	begin
		tcnt <= tcnt + 2'd1;
		tick <= (tcnt == 2'd3);
		mem_ack <= 1'b0;
		if (mem_req && !mem_ack)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr];
			if (mem_we)
				mem[mem_addr] <= mem_wdata;
		end
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			num_errors++;
			close_out();
		end
	end
	task close_out;
		$display("Compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// Polls a status bit; a miss shows up in the comparison that follows
	task wait_st(input int b);
		repeat (300)
		begin
			rd(`SPD_OFF_ISTAT);
			if (d[b] === 1'b1)
				break;
		end
	endtask : wait_st
	task xfer(input logic [3:0] m);
		wr(`SPD_OFF_CTRL1, {26'h0, 2'b10, m});
		@(negedge clk);
		chk("sck_oe", {31'h0, sck_oe}, 32'h1);
		wr(`SPD_OFF_ICLR, 32'hf);
		wr(`SPD_OFF_BUF, 32'ha5);
		wait_st(`SPD_IRQ_XFER);
		rd(`SPD_OFF_BUF);
		chk("rx byte", d, 32'h3c);
		chk("peer rx", {24'h0, prx}, 32'ha5);
	endtask : xfer
	initial
	begin
		mem[12'h010] = 8'h11;
		mem[12'h011] = 8'h22;
		mem[12'h012] = 8'h33;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`SPD_OFF_CTRL1);
		chk("ctrl1 rst", d, 32'h0);
		chk("sck_oe off", {31'h0, sck_oe}, 32'h0);
		rd(8'h3c);
		chk("unmapped", {30'h0, r}, 32'h2);
		wr(`SPD_OFF_DCTRL2, 32'h3);
		rd(`SPD_OFF_DCTRL2);
		chk("dctrl2", d, 32'h3);
		wr(`SPD_OFF_DCTRL2, 32'h0);
		$display("test regs done");
		xfer(SPD_MST_D8);
		xfer(SPD_MST_D16);
		xfer(SPD_MST_D64);
		xfer(SPD_MST_TMR);
		$display("test modes done");
		wr(`SPD_OFF_IEN, 32'h1);
		xfer(SPD_MST_D8);
		repeat (2) @(posedge clk);
		chk("irq set", {31'h0, irq}, 32'h1);
		wr(`SPD_OFF_ICLR, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq clr", {31'h0, irq}, 32'h0);
		$display("test irq done");
		wr(`SPD_OFF_CTRL1, 32'h27);
		wr(`SPD_OFF_BUF, 32'h5a);
		repeat (600) @(posedge clk);
		rd(`SPD_OFF_ISTAT);
		chk("bad mode", d, 32'h0);
		$display("test reserved done");
		wr(`SPD_OFF_CTRL1, 32'h2a);
		wr(`SPD_OFF_TXPTR, 32'h010);
		wr(`SPD_OFF_RXPTR, 32'h020);
		wr(`SPD_OFF_COUNT, 32'h2);
		wr(`SPD_OFF_DCTRL1, 32'h7);
		wait_st(`SPD_IRQ_DMA);
		chk("mem rx0", {24'h0, mem[12'h020]}, 32'h3c);
		chk("mem rx1", {24'h0, mem[12'h021]}, 32'h3c);
		chk("peer dma", {24'h0, prx}, 32'h22);
		rd(`SPD_OFF_DCTRL1);
		chk("dma en", {31'h0, d[0]}, 32'h0);
		rd(`SPD_OFF_TXPTR);
		chk("txptr", d, 32'h012);
		rd(`SPD_OFF_RXPTR);
		chk("rxptr", d, 32'h022);
		rd(`SPD_OFF_COUNT);
		chk("count", d, 32'h0);
		rd(`SPD_OFF_STAT);
		chk("buf full", {31'h0, d[0]}, 32'h0);
		$display("test dma done");
		sleep <= 1'b1;
		wr(`SPD_OFF_ICLR, 32'hf);
		wr(`SPD_OFF_COUNT, 32'h1);
		wr(`SPD_OFF_DCTRL1, 32'h7);
		repeat (50) @(posedge clk);
		rd(`SPD_OFF_COUNT);
		chk("sleep hold", d, 32'h1);
		sleep <= 1'b0;
		wait_st(`SPD_IRQ_DMA);
		rd(`SPD_OFF_COUNT);
		chk("wake count", d, 32'h0);
		chk("peer wake", {24'h0, prx}, 32'h33);
		$display("test sleep done");
		close_out();
	end
endmodule : spd_top_tb
